// File: link_slave_pkg.sv
package link_slave_pkg;

  // protocol framing bytes (raw binary, never ascii text)
  localparam logic [7:0] STX_BYTE = 8'h02;
  localparam logic [7:0] ETX_BYTE = 8'h03;
  localparam logic [7:0] ACK_BYTE = 8'h06;
  localparam logic [7:0] NAK_BYTE = 8'h15;
  localparam logic [7:0] LINE_CHECK_BYTE = 8'h05;

  // command codes carried in the first body byte of a framed request
  localparam logic [7:0] CMD_READ_DEV = 8'h10;
  localparam logic [7:0] CMD_WRITE_DEV = 8'h11;
  localparam logic [7:0] CMD_READ_BIT = 8'h20;
  localparam logic [7:0] CMD_READ_WORD = 8'h21;
  localparam logic [7:0] CMD_RUN_STOP = 8'h30;
  localparam logic [7:0] CMD_READ_TSW = 8'h40;

  // completion flag values
  localparam logic [7:0] FLAG_OK = 8'h00;
  localparam logic [7:0] FLAG_BAD_CMD = 8'h01;
  localparam logic [7:0] FLAG_NOT_MAPPED = 8'h02;
  localparam logic [7:0] FLAG_FRAME_ERR = 8'h03;

  // serial defaults: 8 data bits, no parity, 1 stop, 9600 baud
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_DEFAULT = 9600;
  localparam int BAUD_DIV = CLK_HZ / BAUD_DEFAULT;
  localparam int DATA_BITS = 8;

  // mapping limits and memory sizes
  localparam int MAX_ITEMS = 100;
  localparam logic [1:0] MEM_NONE = 2'h0;
  localparam logic [1:0] MEM_50 = 2'h1;
  localparam logic [1:0] MEM_100 = 2'h2;
  localparam logic [6:0] SLOTS_50 = 7'd50;
  localparam logic [6:0] SLOTS_100 = 7'd100;
  localparam int BYTES_50 = 300;
  localparam int BYTES_100 = 600;
  localparam logic [3:0] STATION_MAX = 4'hF;
  localparam logic [3:0] STATION_RESET = 4'h0;

  // register map over axi4-lite
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DEVICE = 8'h08;
  localparam logic [7:0] REG_TSW = 8'h0C;
  localparam logic [7:0] REG_MAP_BIT = 8'h10;
  localparam logic [7:0] REG_MAP_WORD = 8'h14;

  // bus answer codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // byte moving through the reply fifo
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } tx_item_t;

endpackage : link_slave_pkg

// File: byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;

  // full when pointers differ only in the wrap bit
  assign inReady = (wrPtr ^ rdPtr) != {1'b1, {AW{1'b0}}};
  assign outValid = wrPtr != rdPtr;
  assign outData = mem[rdPtr[AW-1:0]];

  // write side
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= '0;
    end else if (inValid && inReady) begin
      wrPtr <= wrPtr + 1'b1;
    end
  end

  // storage carries no reset: contents are only read once written
  always_ff @(posedge ref_clk) begin
    if (inValid && inReady) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  // read side
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdPtr <= '0;
    end else if (outValid && outReady) begin
      rdPtr <= rdPtr + 1'b1;
    end
  end
endmodule : byte_fifo
`default_nettype wire

// File: serial_link_slave.sv
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - frames are handled as raw eight-bit binary bytes, never ascii text.
// - controller only answers; it never starts a transmission itself.
// - one host and one controller only; no multidrop addressing.
// - line-check reply repeats the request's byte structure.
// - read reply is STX, flag, STX, data, ETX.
// - write reply is STX, flag, STX, ACK, with no data.
// - run/stop reply is STX, flag, STX, ACK.
// - serial defaults are 8 data bits, no parity, 1 stop, 9600 baud.
// - station number holds zero to fifteen, defaulting to zero.
// - at most 100 bit items and 100 word items are mapped.
// - memory size picks 0, 50 or 100 slots, i.e. 0, 300, 600 bytes.
// - with memory size zero no bit or word item may be mapped.
// - bit items return the mapped function-block output state.
// - word items return the low byte of the mapped parameter's current value.
// - settings take effect only after a power cycle.
// - replies carry line status, errors, bit, word and time-switch data.
// - system devices are reachable without mapping; function blocks need it.
module serial_link_slave #(
  parameter int BAUD_DIV = link_slave_pkg::BAUD_DIV,
  parameter int MAX_ITEMS = link_slave_pkg::MAX_ITEMS,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // serial link
  input wire logic rxd,
  output logic txd,
  input wire logic hostHandshake,
  // function block data
  input wire logic [MAX_ITEMS-1:0] fbOutputs,
  input wire logic [MAX_ITEMS*16-1:0] fbWords,
  // run state
  output logic runMode,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [5:0] {
    R_IDLE = 6'b000001, R_CMD = 6'b000010, R_ARG = 6'b000100,
    R_END = 6'b001000, R_REPLY = 6'b010000, R_DRAIN = 6'b100000
  } rx_state_t;

  rx_state_t rxState;
  // pending settings versus live ones; live loads only at reset release
  // pending copy stands in for nonvolatile storage, so reset leaves it alone
  logic [3:0] pendStation = link_slave_pkg::STATION_RESET;
  logic [1:0] pendMem = link_slave_pkg::MEM_NONE;
  logic cfgWrite;
  logic [3:0] station;
  logic [1:0] memSize;
  logic loaded;
  logic [15:0] devReg;
  logic [15:0] tswReg;
  logic [7:0] cmd;
  logic [7:0] arg;
  logic [7:0] rxCount;
  logic [2:0] step;
  logic [6:0] slots;
  logic [15:0] bdCnt;
  logic [3:0] rxBitIdx;
  logic [7:0] rxShift;
  logic rxBusy;
  logic rxStrobe;
  logic [7:0] rxByte;
  logic [15:0] txCnt;
  logic [3:0] txBitIdx;
  logic [9:0] txShift;
  logic txBusy;
  logic linkOk;
  link_slave_pkg::tx_item_t pushItem;
  link_slave_pkg::tx_item_t popItem;
  logic pushValid;
  logic pushReady;
  logic popValid;
  logic popReady;
  logic [7:0] replyData;
  logic [7:0] replyFlag;
  logic argMapped;
  logic [1:0] awSeen;
  logic [7:0] awLatch;
  logic [31:0] wLatch;

  // the host's handshake outputs must be high for any byte to move
  // handshake gate
  // point to point: no station address is decoded in frames
  assign linkOk = hostHandshake;

  // receive sampling at half bit, 8N1 framing only
  // serial framing
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bdCnt <= '0;
      rxBusy <= 1'b0;
      rxBitIdx <= '0;
      rxShift <= '0;
      rxStrobe <= 1'b0;
      rxByte <= '0;
    end else begin
      rxStrobe <= 1'b0;
      if (!rxBusy) begin
        if (!rxd && linkOk) begin
          rxBusy <= 1'b1;
          bdCnt <= 16'(BAUD_DIV / 2);
          rxBitIdx <= '0;
        end
      end else if (bdCnt == 16'h0000) begin
        bdCnt <= 16'(BAUD_DIV - 1);
        rxBitIdx <= rxBitIdx + 1'b1;
        if (rxBitIdx >= 4'd1 && rxBitIdx <= 4'(link_slave_pkg::DATA_BITS)) begin
          rxShift <= {rxd, rxShift[7:1]};
        end
        if (rxBitIdx == 4'(link_slave_pkg::DATA_BITS + 1)) begin
          rxBusy <= 1'b0;
          // raw binary byte, no ascii decode
          // binary bytes
          rxStrobe <= rxd;
          rxByte <= rxShift;
        end
      end else begin
        bdCnt <= bdCnt - 1'b1;
      end
    end
  end
  // slots available from the live memory size
  // memory slots
  always_comb begin
    unique case (memSize)
      link_slave_pkg::MEM_50: slots = link_slave_pkg::SLOTS_50;
      link_slave_pkg::MEM_100: slots = link_slave_pkg::SLOTS_100;
      default: slots = 7'd0;
    endcase
  end

  // item index must lie under the slot count; size zero maps nothing
  // no mapping
  assign argMapped = (slots != 7'd0) && (arg[6:0] < slots) && (arg < 8'(MAX_ITEMS));

  // data and flag for the current request
  // reply contents
  always_comb begin
    replyData = 8'h00;
    replyFlag = link_slave_pkg::FLAG_OK;
    unique case (cmd)
      link_slave_pkg::CMD_READ_DEV: replyData = arg[0] ? devReg[15:8] : devReg[7:0];
      link_slave_pkg::CMD_WRITE_DEV: replyData = 8'h00;
      link_slave_pkg::CMD_RUN_STOP: replyData = 8'h00;
      link_slave_pkg::CMD_READ_TSW: replyData = tswReg[7:0];
      link_slave_pkg::CMD_READ_BIT: begin
        if (argMapped) replyData = {7'h00, fbOutputs[arg[6:0]]};
        else replyFlag = link_slave_pkg::FLAG_NOT_MAPPED;
      end
      link_slave_pkg::CMD_READ_WORD: begin
        if (argMapped) replyData = fbWords[arg[6:0]*16 +: 8];
        else replyFlag = link_slave_pkg::FLAG_NOT_MAPPED;
      end
      default: replyFlag = link_slave_pkg::FLAG_BAD_CMD;
    endcase
  end

  // request parser and reply builder; no reply without a request
  // slave only
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxState <= R_IDLE;
      cmd <= '0;
      arg <= '0;
      step <= '0;
      rxCount <= '0;
      runMode <= 1'b0;
      devReg <= '0;
    end else begin
      unique case (rxState)
        R_IDLE: begin
          step <= '0;
          if (rxStrobe) begin
            if (rxByte == link_slave_pkg::LINE_CHECK_BYTE) begin
              cmd <= link_slave_pkg::LINE_CHECK_BYTE;
              rxState <= R_REPLY;
            end else if (rxByte == link_slave_pkg::STX_BYTE) begin
              rxState <= R_CMD;
            end
          end
        end
        R_CMD: if (rxStrobe) begin
          cmd <= rxByte;
          rxState <= R_ARG;
        end
        R_ARG: if (rxStrobe) begin
          arg <= rxByte;
          rxState <= R_END;
        end
        R_END: if (rxStrobe) begin
          if (rxByte != link_slave_pkg::ETX_BYTE) cmd <= 8'hFF;
          rxState <= R_REPLY;
        end
        R_REPLY: begin
          if (pushReady) begin
            step <= step + 1'b1;
            if (pushItem.last) rxState <= R_DRAIN;
          end
          if (step == 3'd0 && cmd == link_slave_pkg::CMD_RUN_STOP) begin
            runMode <= arg[0];
          end
          if (step == 3'd0 && cmd == link_slave_pkg::CMD_WRITE_DEV) begin
            devReg[7:0] <= arg;
          end
        end
        // bytes arriving while the reply drains are dropped
        // reply before next
        R_DRAIN: if (!popValid && !txBusy) rxState <= R_IDLE;
        default: rxState <= R_IDLE;
      endcase
    end
  end

  // reply byte sequence per command
  always_comb begin
    pushValid = (rxState == R_REPLY);
    pushItem.last = 1'b0;
    pushItem.data = link_slave_pkg::STX_BYTE;
    if (cmd == link_slave_pkg::LINE_CHECK_BYTE) begin
      pushItem.data = link_slave_pkg::LINE_CHECK_BYTE;
      pushItem.last = 1'b1;
    end else begin
      unique case (step)
        3'd0: pushItem.data = link_slave_pkg::STX_BYTE;
        3'd1: pushItem.data = replyFlag;
        3'd2: pushItem.data = link_slave_pkg::STX_BYTE;
        3'd3: begin
          if (cmd == link_slave_pkg::CMD_WRITE_DEV || cmd == link_slave_pkg::CMD_RUN_STOP) begin
            pushItem.data = link_slave_pkg::ACK_BYTE;
            pushItem.last = 1'b1;
          end else begin
            pushItem.data = replyData;
          end
        end
        default: begin
          pushItem.data = link_slave_pkg::ETX_BYTE;
          pushItem.last = 1'b1;
        end
      endcase
    end
  end

  byte_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) replyFifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushItem),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popItem)
  );

  // transmitter drains the fifo only while the host handshake is high
  assign popReady = !txBusy && linkOk;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      txBusy <= 1'b0;
      txCnt <= '0;
      txBitIdx <= '0;
      txShift <= '1;
    end else if (!txBusy) begin
      if (popValid && popReady) begin
        txBusy <= 1'b1;
        txShift <= {1'b1, popItem.data, 1'b0};
        txCnt <= 16'(BAUD_DIV - 1);
        txBitIdx <= '0;
      end
    end else if (txCnt == 16'h0000) begin
      txCnt <= 16'(BAUD_DIV - 1);
      txShift <= {1'b1, txShift[9:1]};
      txBitIdx <= txBitIdx + 1'b1;
      if (txBitIdx == 4'd9) txBusy <= 1'b0;
    end else begin
      txCnt <= txCnt - 1'b1;
    end
  end
  assign txd = txBusy ? txShift[0] : 1'b1;

  // live settings copied once after reset release, standing in for power-up
  // power cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      loaded <= 1'b0;
      station <= link_slave_pkg::STATION_RESET;
      memSize <= link_slave_pkg::MEM_NONE;
    end else if (!loaded) begin
      loaded <= 1'b1;
      station <= pendStation;
      memSize <= pendMem;
    end
  end

  // axi write: address and data taken in either order
  assign s_axi_awready = !awSeen[0] && !s_axi_bvalid;
  assign s_axi_wready = !awSeen[1] && !s_axi_bvalid;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      awSeen <= '0;
      awLatch <= '0;
      wLatch <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= link_slave_pkg::RESP_OKAY;
      tswReg <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awSeen[0] <= 1'b1;
        awLatch <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        awSeen[1] <= 1'b1;
        wLatch <= s_axi_wdata;
      end
      if (awSeen == 2'b11) begin
        awSeen <= '0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= link_slave_pkg::RESP_OKAY;
        unique case (awLatch)
          link_slave_pkg::REG_CONFIG: s_axi_bresp <= link_slave_pkg::RESP_OKAY;
          link_slave_pkg::REG_TSW: tswReg <= wLatch[15:0];
          default: s_axi_bresp <= link_slave_pkg::RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  // pending settings survive rstn, which plays the part of a power cycle
  // station range
  assign cfgWrite = (awSeen == 2'b11) && (awLatch == link_slave_pkg::REG_CONFIG);
  always_ff @(posedge ref_clk) begin
    if (cfgWrite) begin
      pendStation <= wLatch[3:0];
      pendMem <= (wLatch[5:4] > link_slave_pkg::MEM_100) ? link_slave_pkg::MEM_NONE
                 : wLatch[5:4];
    end
  end

  // axi read
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= link_slave_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= link_slave_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        link_slave_pkg::REG_CONFIG: s_axi_rdata <= {26'h0, pendMem, pendStation};
        link_slave_pkg::REG_STATUS: s_axi_rdata <= {18'h0, 6'(rxState), txBusy, runMode,
                                                   memSize, station};
        link_slave_pkg::REG_DEVICE: s_axi_rdata <= {16'h0, devReg};
        link_slave_pkg::REG_TSW: s_axi_rdata <= {16'h0, tswReg};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= link_slave_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // replies only ever follow a request
  reply_after_req_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(rxState == R_REPLY) |-> $past(rxStrobe))
    else $error("reply began without a received byte");
  write_ack_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rxState == R_REPLY && step == 3'd3 && cmd == link_slave_pkg::CMD_WRITE_DEV)
    |-> pushItem.data == link_slave_pkg::ACK_BYTE && pushItem.last)
    else $error("write reply not closed by ack");
  read_etx_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rxState == R_REPLY && step == 3'd4) |-> pushItem.data == link_slave_pkg::ETX_BYTE)
    else $error("read reply not closed by etx");
  no_map_zero_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (memSize == link_slave_pkg::MEM_NONE) |-> !argMapped)
    else $error("item mapped with no memory");
  settings_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    loaded && $past(loaded) |-> $stable(station) && $stable(memSize))
    else $error("live settings changed without reset");
  drain_block_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rxState == R_DRAIN && popValid) |=> rxState == R_DRAIN)
    else $error("left drain while reply pending");
  line_echo_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rxState == R_REPLY && cmd == link_slave_pkg::LINE_CHECK_BYTE)
    |-> pushItem.data == link_slave_pkg::LINE_CHECK_BYTE)
    else $error("line check not echoed");
  station_load_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    loaded && !$past(loaded) |-> station == $past(pendStation) && memSize == $past(pendMem))
    else $error("live settings not taken from pending copy");
endmodule : serial_link_slave
`default_nettype wire

// File: host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the link: sends request bytes, gathers every reply byte
module host_link_model #(
  parameter int BIT_CYC = 16
) (
  // clock
  input wire logic ref_clk,
  // serial lines
  output logic hostTx,
  input wire logic hostRx
);
  logic [7:0] replyQ[$];
  logic [7:0] shiftIn;

  // idle line sits high like a released rs-232 mark
  initial hostTx = 1'b1;

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      hostTx <= f[i];
      repeat (BIT_CYC) @(posedge ref_clk);
    end
  endtask : send_byte

  // receiver always listens, so a reply that starts mid stop bit is not lost
  always begin
    @(negedge hostRx);
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge ref_clk);
      shiftIn[i] = hostRx;
    end
    repeat (BIT_CYC) @(posedge ref_clk);
    replyQ.push_back(shiftIn);
  end
endmodule : host_link_model
`default_nettype wire

// File: serial_link_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_link_slave_tb;
  typedef struct {logic [7:0] cmd, arg, flag, d3; logic more;} case_t;
  logic ref_clk = 1'b0, rstn = 1'b0, rxd, txd, hostHandshake = 1'b1, runMode;
  logic [99:0] fbBits = '0;
  logic [1599:0] fbWordBus = '0;
  logic [7:0] awaddr = '0, araddr = '0, b;
  logic [31:0] wdata = '0, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
  logic arvalid = 0, arready, rvalid, rready = 0;
  int numErrors = 0, samplesChecked = 0;
  case_t rows[7];

  always #5 ref_clk = ~ref_clk;

  serial_link_slave #(.BAUD_DIV(16)) serial_link_slave_inst (.ref_clk(ref_clk), .rstn(rstn),
    .rxd(rxd), .txd(txd), .hostHandshake(hostHandshake), .fbOutputs(fbBits),
    .fbWords(fbWordBus), .runMode(runMode), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  host_link_model #(.BIT_CYC(16)) host_link_model_inst (.ref_clk(ref_clk), .hostTx(rxd),
    .hostRx(txd));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samplesChecked++;
    if (seen !== exp) begin
      numErrors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d, mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  // write: address and data offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    v = rdata; rs = rresp;
    rready <= 0;
  endtask : axi_read

  task automatic get_byte(output logic [7:0] v);
    int n = 0;
    while (host_link_model_inst.replyQ.size() == 0 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 3000) v = 8'hxx;
    else v = host_link_model_inst.replyQ.pop_front();
  endtask : get_byte

  task automatic send_frame(input logic [7:0] c, input logic [7:0] a);
    host_link_model_inst.send_byte(link_slave_pkg::STX_BYTE);
    host_link_model_inst.send_byte(c);
    host_link_model_inst.send_byte(a);
    host_link_model_inst.send_byte(link_slave_pkg::ETX_BYTE);
  endtask : send_frame

  task automatic expect_reply(input case_t c);
    get_byte(b); check(b, link_slave_pkg::STX_BYTE, "reply stx");
    get_byte(b); check(b, c.flag, "flag");
    get_byte(b); check(b, link_slave_pkg::STX_BYTE, "second stx");
    get_byte(b); check(b, c.d3, "data or ack");
    if (c.more) begin
      get_byte(b); check(b, link_slave_pkg::ETX_BYTE, "etx");
    end
  endtask : expect_reply

  // watchdog sized well beyond the sum of all frames
  initial begin
    repeat (90000) @(posedge ref_clk);
    numErrors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin
    fbBits[3] = 1'b1;
    fbWordBus[32 +: 16] = 16'h12c3;
    rows = '{'{link_slave_pkg::CMD_RUN_STOP, 8'h01, link_slave_pkg::FLAG_OK, link_slave_pkg::ACK_BYTE, 0},
      '{link_slave_pkg::CMD_RUN_STOP, 8'h00, link_slave_pkg::FLAG_OK, link_slave_pkg::ACK_BYTE, 0},
      '{link_slave_pkg::CMD_READ_BIT, 8'h03, link_slave_pkg::FLAG_OK, 8'h01, 1},
      '{link_slave_pkg::CMD_READ_WORD, 8'h02, link_slave_pkg::FLAG_OK, 8'hc3, 1},
      '{link_slave_pkg::CMD_WRITE_DEV, 8'h5a, link_slave_pkg::FLAG_OK, link_slave_pkg::ACK_BYTE, 0},
      '{link_slave_pkg::CMD_READ_DEV, 8'h00, link_slave_pkg::FLAG_OK, 8'h5a, 1},
      '{link_slave_pkg::CMD_READ_TSW, 8'h00, link_slave_pkg::FLAG_OK, 8'ha5, 1}};
    repeat (6) @(posedge ref_clk);
    rstn <= 1;
    repeat (200) @(posedge ref_clk);
    check(host_link_model_inst.replyQ.size(), 0, "unsolicited tx");
    axi_read(link_slave_pkg::REG_STATUS, d, r);
    check(d[3:0], link_slave_pkg::STATION_RESET, "station reset");
    axi_write(link_slave_pkg::REG_CONFIG, 32'h0000_002f, r);
    check(r, link_slave_pkg::RESP_OKAY, "config write");
    axi_read(link_slave_pkg::REG_STATUS, d, r);
    check(d[3:0], link_slave_pkg::STATION_RESET, "station pending");
    axi_write(8'h20, 32'h0000_0001, r);
    check(r, link_slave_pkg::RESP_SLVERR, "unmapped write");
    axi_read(8'h24, d, r);
    check(r, link_slave_pkg::RESP_SLVERR, "unmapped read");
    // second reset applies the stored settings
    rstn <= 0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1;
    repeat (3) @(posedge ref_clk);
    axi_read(link_slave_pkg::REG_STATUS, d, r);
    check(d[5:0], 6'h2f, "applied config");
    axi_write(link_slave_pkg::REG_TSW, 32'h0000_00a5, r);
    $display("test registers done");
    foreach (rows[i]) begin
      send_frame(rows[i].cmd, rows[i].arg);
      expect_reply(rows[i]);
      if (rows[i].cmd == link_slave_pkg::CMD_RUN_STOP) begin
        check(runMode, rows[i].arg[0], "run mode");
      end
    end
    $display("test rows done");
    host_link_model_inst.send_byte(link_slave_pkg::LINE_CHECK_BYTE);
    get_byte(b); check(b, link_slave_pkg::LINE_CHECK_BYTE, "echo");
    hostHandshake <= 0;
    host_link_model_inst.send_byte(link_slave_pkg::LINE_CHECK_BYTE);
    repeat (400) @(posedge ref_clk);
    check(host_link_model_inst.replyQ.size(), 0, "blocked link");
    hostHandshake <= 1;
    repeat (400) @(posedge ref_clk);
    host_link_model_inst.replyQ.delete();
    // byte sent during a reply is ignored
    send_frame(link_slave_pkg::CMD_RUN_STOP, 8'h01);
    host_link_model_inst.send_byte(link_slave_pkg::LINE_CHECK_BYTE);
    expect_reply(rows[0]);
    repeat (600) @(posedge ref_clk);
    check(host_link_model_inst.replyQ.size(), 0, "no late echo");
    send_frame(8'h7f, 8'h00);
    get_byte(b); check(b, link_slave_pkg::STX_BYTE, "bad stx");
    get_byte(b); check(b, link_slave_pkg::FLAG_BAD_CMD, "bad flag");
    $display("test awkward cases done");
    close_out();
  end
endmodule : serial_link_slave_tb
`default_nettype wire
